/* core/eepc_pkg.sv */
// Package for the word-addressed nonvolatile store controller
package eepc_pkg;

	// Register byte offsets on the AXI4-Lite slave
	localparam logic [7:0] EEPC_OFF_ADDR   = 8'h00;
	localparam logic [7:0] EEPC_OFF_WDATA  = 8'h04;
	localparam logic [7:0] EEPC_OFF_RDATA  = 8'h08;
	localparam logic [7:0] EEPC_OFF_CMD    = 8'h0c;
	localparam logic [7:0] EEPC_OFF_STATUS = 8'h10;
	localparam logic [7:0] EEPC_OFF_SIZE   = 8'h14;
	localparam logic [7:0] EEPC_OFF_RIS    = 8'h18;
	localparam logic [7:0] EEPC_OFF_MIS    = 8'h1c;
	localparam logic [7:0] EEPC_OFF_IEN    = 8'h20;
	localparam logic [7:0] EEPC_OFF_ICLR   = 8'h24;
	localparam logic [7:0] EEPC_OFF_FMASK  = 8'h28;

	// Store geometry
	localparam int          EEPC_WORDS     = 64;
	localparam int          EEPC_AW        = 6;
	localparam logic [31:0] EEPC_SIZE_BYTES = 32'h0000_0100;
	localparam logic [31:0] EEPC_ERASED    = 32'hffff_ffff;

	// Command codes written to the command register
	localparam logic [1:0] EEPC_CMD_PROG  = 2'h1;
	localparam logic [1:0] EEPC_CMD_READ  = 2'h2;
	localparam logic [1:0] EEPC_CMD_ERASE = 2'h3;

	// Status flag positions
	localparam int EEPC_ST_INVPAR = 0;
	localparam int EEPC_ST_BUSY   = 1;
	localparam int EEPC_ST_NOPERM = 2;
	localparam int EEPC_ST_WCOPY  = 3;
	localparam int EEPC_ST_WERASE = 4;
	localparam int EEPC_ST_ACTIVE = 5;

	// Interrupt bit positions
	localparam int EEPC_INT_PROG  = 0;
	localparam int EEPC_FM_EEPROM = 2;

	// Cell program time, in ns, and its count at 20 MHz
	localparam int EEPC_CLK_NS    = 50;
	localparam int EEPC_PROG_NS   = 400;
	localparam int EEPC_PROG_CYC  = (EEPC_PROG_NS + EEPC_CLK_NS - 1)
		/ EEPC_CLK_NS;
	localparam logic [7:0] EEPC_PROG_CNT = 8'(EEPC_PROG_CYC);

	typedef enum logic [1:0] {
		EEPC_IDLE  = 2'b00,
		EEPC_PROG  = 2'b01,
		EEPC_ERASE = 2'b10
	} eepc_state_e;

	// AXI4-Lite slave-side outputs
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} eepc_axi_out_s;

	// AXI4-Lite master-side inputs
	typedef struct packed {
		logic        awvalid;
		logic [7:0]  awaddr;
		logic        wvalid;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bready;
		logic        arvalid;
		logic [7:0]  araddr;
		logic        rready;
	} eepc_axi_in_s;

endpackage : eepc_pkg

/* core/eepc_top.sv */
// Store controller: AXI4-Lite registers, program/erase engine, interrupt
//
// Overview of operation
// - With the enable and the flash mask set, every finished program or erase raises the irq.
// - With the enable clear, completions never drive the irq line.
// - The irq is one line shared with flash, gated by its own mask bit.
// - Software reads the completion bit raw or masked at two offsets.
// - Only one interrupt source exists; raw, masked, enable and clear use bit 0, the flash mask bit 2.
// - Mass erase writes all ones to every word and drops all protection.
// - A single-word program is taken at once and finishes in background.
// - Status has six flags: bad param, busy, no perm, copy, erase, active.
// - Status reads zero after a clean finish, flags while busy or failed.
// - Capacity in bytes is readable.
// - Erase runs to its end before completion; nonzero status is failure.
`timescale 1ns/1ps
module eepc_top (
	input  wire logic                    clock,
	input  wire logic                    rst,
	input  wire eepc_pkg::eepc_axi_in_s  axi_in,
	output eepc_pkg::eepc_axi_out_s      axi_out,
	output logic                         irq,
	output logic                         protect_clear
);
	import eepc_pkg::*;

	typedef struct packed {
		eepc_axi_out_s axi;
		eepc_state_e   state;
		logic [7:0]    cnt;
		logic [EEPC_AW-1:0] ptr;
		logic [31:0]   addr;
		logic [31:0]   wdata;
		logic [31:0]   rdata;
		logic [5:0]    status;
		logic          ris;
		logic          ien;
		logic          fmask;
		logic          irq;
		logic          unprot;
	} eepc_st_s;

	eepc_st_s st_reg;
	eepc_st_s st_next;
	logic [31:0] mem [EEPC_WORDS];

	logic        wr_go;
	logic        rd_go;
	logic [31:0] rd_val;
	logic        done;
	logic        mem_we;
	logic [EEPC_AW-1:0] mem_a;
	logic [31:0] mem_d;
	logic        bad_addr;

	assign wr_go = axi_in.awvalid && axi_in.wvalid && !st_reg.axi.bvalid;
	assign rd_go = axi_in.arvalid && !st_reg.axi.rvalid;
	assign bad_addr = (st_reg.addr[1:0] != 2'h0) ||
		(st_reg.addr >= EEPC_SIZE_BYTES);
	assign axi_out = st_reg.axi;
	assign irq = st_reg.irq;
	assign protect_clear = st_reg.unprot;

	////////////////////////////////////////////////////////////////////////
	// Read mux, raw and masked interrupt views
	always_comb begin
		rd_val = 32'h0;
		case (axi_in.araddr)
			EEPC_OFF_ADDR:   rd_val = st_reg.addr;
			EEPC_OFF_WDATA:  rd_val = st_reg.wdata;
			EEPC_OFF_RDATA:  rd_val = st_reg.rdata;
			EEPC_OFF_STATUS: rd_val = {26'h0, st_reg.status};
			EEPC_OFF_SIZE:   rd_val = EEPC_SIZE_BYTES;
			EEPC_OFF_RIS:    rd_val = {31'h0, st_reg.ris};
			EEPC_OFF_MIS:    rd_val = {31'h0, st_reg.ris & st_reg.ien};
			EEPC_OFF_IEN:    rd_val = {31'h0, st_reg.ien};
			EEPC_OFF_FMASK:  rd_val = {29'h0, st_reg.fmask, 2'h0};
			default:         rd_val = 32'h0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic: bus, engine, flags
	always_comb begin
		st_next = st_reg;
		done = 1'b0;
		mem_we = 1'b0;
		mem_a = st_reg.addr[EEPC_AW+1:2];
		mem_d = st_reg.wdata;
		st_next.unprot = 1'b0;
		st_next.axi.awready = 1'b0;
		st_next.axi.wready = 1'b0;
		st_next.axi.arready = 1'b0;
		if (st_reg.axi.bvalid && axi_in.bready)
			st_next.axi.bvalid = 1'b0;
		if (st_reg.axi.rvalid && axi_in.rready)
			st_next.axi.rvalid = 1'b0;

		// Engine runs first; its done flag sets ris below, after the bus clear, so the clear cannot hide it
		case (st_reg.state)
			EEPC_IDLE: begin
			end
			EEPC_PROG: begin
				st_next.cnt = st_reg.cnt - 8'h1;
				if (st_reg.cnt == 8'h1) begin
					mem_we = 1'b1;
					st_next.state = EEPC_IDLE;
					st_next.status = 6'h0;
					done = 1'b1;
				end
			end
			EEPC_ERASE: begin
				// One word per cycle; done only after the last word
				mem_we = 1'b1;
				mem_a = st_reg.ptr;
				mem_d = EEPC_ERASED;
				st_next.ptr = st_reg.ptr + 1'b1;
				if (st_reg.ptr == EEPC_AW'(EEPC_WORDS - 1)) begin
					st_next.state = EEPC_IDLE;
					st_next.status = 6'h0;
					st_next.unprot = 1'b1;
					done = 1'b1;
				end
			end
			default: st_next.state = EEPC_IDLE;
		endcase

		// Writes: both channels taken in the same cycle
		if (wr_go) begin
			st_next.axi.awready = 1'b1;
			st_next.axi.wready = 1'b1;
			st_next.axi.bvalid = 1'b1;
			st_next.axi.bresp = 2'b00;
			case (axi_in.awaddr)
				EEPC_OFF_ADDR:  st_next.addr = axi_in.wdata;
				EEPC_OFF_WDATA: st_next.wdata = axi_in.wdata;
				EEPC_OFF_IEN:   st_next.ien = axi_in.wdata[EEPC_INT_PROG];
				EEPC_OFF_FMASK: st_next.fmask = axi_in.wdata[EEPC_FM_EEPROM];
				EEPC_OFF_ICLR:
					if (axi_in.wdata[EEPC_INT_PROG])
						st_next.ris = 1'b0;
				EEPC_OFF_CMD:
					if (st_reg.state != EEPC_IDLE) begin
						st_next.status[EEPC_ST_BUSY] = 1'b1;
					end else if (axi_in.wdata[1:0] == EEPC_CMD_ERASE) begin
						st_next.state = EEPC_ERASE;
						st_next.ptr = '0;
						st_next.status = 6'h0;
						st_next.status[EEPC_ST_WERASE] = 1'b1;
						st_next.status[EEPC_ST_ACTIVE] = 1'b1;
					end else if (bad_addr) begin
						st_next.status = 6'h0;
						st_next.status[EEPC_ST_INVPAR] = 1'b1;
					end else if (axi_in.wdata[1:0] == EEPC_CMD_PROG) begin
						st_next.state = EEPC_PROG;
						st_next.cnt = EEPC_PROG_CNT;
						st_next.status = 6'h0;
						st_next.status[EEPC_ST_WCOPY] = 1'b1;
						st_next.status[EEPC_ST_ACTIVE] = 1'b1;
					end else if (axi_in.wdata[1:0] == EEPC_CMD_READ) begin
						st_next.rdata = mem[st_reg.addr[EEPC_AW+1:2]];
					end
				EEPC_OFF_STATUS, EEPC_OFF_SIZE, EEPC_OFF_RIS, EEPC_OFF_MIS,
				EEPC_OFF_RDATA: begin
				end
				default: st_next.axi.bresp = 2'b10;
			endcase
		end

		// Completion sets after the clear so set wins
		if (done)
			st_next.ris = 1'b1;

		if (rd_go) begin
			st_next.axi.arready = 1'b1;
			st_next.axi.rvalid = 1'b1;
			st_next.axi.rdata = rd_val;
			st_next.axi.rresp = 2'b00;
		end

		// Shared line: source enable and flash-side mask both needed
		st_next.irq = st_next.ris & st_next.ien & st_next.fmask;
	end

	////////////////////////////////////////////////////////////////////////
	// State register and storage array
	always_ff @(posedge clock) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.state <= EEPC_IDLE;
			st_reg.fmask <= 1'b1;
		end else begin
			st_reg <= st_next;
		end
		if (mem_we)
			mem[mem_a] <= mem_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	sequence s_prog_start;
		st_reg.state == EEPC_IDLE && st_next.state == EEPC_PROG;
	endsequence

	chk_irq_follows: assert property (
		$rose(st_reg.ris) && st_reg.ien && st_reg.fmask |-> irq)
		else $error("irq missing after completion");
	chk_irq_gated: assert property (
		!st_reg.ien || !st_reg.fmask |-> !irq)
		else $error("irq while disabled");
	chk_irq_merge: assert property (
		irq |-> st_reg.ris && st_reg.fmask)
		else $error("irq without source");
	chk_mis_view: assert property (
		rd_go && axi_in.araddr == EEPC_OFF_MIS |=>
		axi_out.rdata[0] == $past(st_reg.ris & st_reg.ien))
		else $error("masked view wrong");
	chk_prog_len: assert property (
		s_prog_start |=> (st_reg.state == EEPC_PROG)[*8] ##1
		st_reg.state == EEPC_IDLE && st_reg.ris)
		else $error("program length wrong");
	chk_done_status: assert property (
		$fell(st_reg.status[EEPC_ST_ACTIVE]) && st_reg.state == EEPC_IDLE
		|-> st_reg.status == 6'h0)
		else $error("status not zero after finish");
	chk_erase_len: assert property (
		st_reg.state == EEPC_IDLE && st_next.state == EEPC_ERASE
		|=> st_reg.status[EEPC_ST_WERASE] ##64 st_reg.state == EEPC_IDLE
		##0 st_reg.ris)
		else $error("erase ended early");
	chk_erase_ones: assert property (
		st_reg.state == EEPC_ERASE |-> mem_we && mem_d == EEPC_ERASED)
		else $error("erase data wrong");
	chk_busy_reject: assert property (
		wr_go && axi_in.awaddr == EEPC_OFF_CMD && st_reg.state != EEPC_IDLE
		|=> st_reg.status[EEPC_ST_BUSY])
		else $error("busy program not rejected");
	chk_unprotect: assert property (
		$fell(st_reg.state == EEPC_ERASE) |-> protect_clear)
		else $error("protection not dropped");
	chk_size_read: assert property (
		rd_go && axi_in.araddr == EEPC_OFF_SIZE |=>
		axi_out.rdata == EEPC_SIZE_BYTES)
		else $error("size read wrong");

endmodule : eepc_top

/* verification/eeprom_program_status_irq_tb_top.sv */
// Self-checking bench for the store controller over its register bus
`timescale 1ns/1ps
module eeprom_program_status_irq_tb_top;
	import eepc_pkg::*;
	logic          clock;
	logic          rst;
	eepc_axi_in_s  ai;
	eepc_axi_out_s ao;
	logic          irq;
	logic          protect_clear;
	int            n_mismatch;
	int            cmp_count;
	int            cyc = 0;
	logic [31:0]   rdv;
	logic [1:0]    rsp;

	eepc_top i_dut (
		.clock         (clock),
		.rst           (rst),
		.axi_in        (ai),
		.axi_out       (ao),
		.irq           (irq),
		.protect_clear (protect_clear)
	);

	////////////////////////////////////////////////////////////////////////
	// 20 MHz clock
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	// Watchdog, far above the whole scenario chain
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			n_mismatch++;
			conclude();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t %s got %h want %h", $time, msg, seen, exp);
		end
	endtask : chk

	// Write: both channels offered together, each dropped on its own ready
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok  = 1'b0;
		@(posedge clock);
		ai.awvalid <= 1'b1;
		ai.awaddr  <= a;
		ai.wvalid  <= 1'b1;
		ai.wdata   <= d;
		ai.wstrb   <= 4'hf;
		ai.bready  <= 1'b1;
		while (!(aw_ok && w_ok)) begin
			@(posedge clock);
			if (ao.awready === 1'b1) begin
				ai.awvalid <= 1'b0;
				aw_ok = 1'b1;
			end
			if (ao.wready === 1'b1) begin
				ai.wvalid <= 1'b0;
				w_ok = 1'b1;
			end
		end
		while (ao.bvalid !== 1'b1) @(posedge clock);
		rsp = ao.bresp;
		ai.bready <= 1'b0;
	endtask : wr

	// Read and compare; data taken at the rvalid edge
	task automatic rc(input logic [7:0] a, input logic [31:0] e,
		input string msg);
		@(posedge clock);
		ai.arvalid <= 1'b1;
		ai.araddr  <= a;
		ai.rready  <= 1'b1;
		do @(posedge clock); while (ao.arready !== 1'b1);
		ai.arvalid <= 1'b0;
		while (ao.rvalid !== 1'b1) @(posedge clock);
		rdv = ao.rdata;
		rsp = ao.rresp;
		ai.rready <= 1'b0;
		chk(rdv, e, msg);
	endtask : rc

	// Bounded wait, since completion time is the engine's business
	task automatic wt_irq();
		for (int n = 0; n < 40 && irq !== 1'b1; n++) @(posedge clock);
		chk({31'h0, irq}, 32'h1, "irq on completion");
	endtask : wt_irq

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rc(EEPC_OFF_STATUS, 32'h0, "status reset");
		rc(EEPC_OFF_SIZE, EEPC_SIZE_BYTES, "size");
		rc(EEPC_OFF_IEN, 32'h0, "enable reset");
		rc(EEPC_OFF_FMASK, 32'h4, "flash mask reset");
		chk({31'h0, irq}, 32'h0, "irq reset");
	endtask : t_reset

	// Program, then a second command while busy must bounce
	task automatic t_prog();
		wr(EEPC_OFF_IEN, 32'h1);
		wr(EEPC_OFF_ADDR, 32'h8);
		wr(EEPC_OFF_WDATA, 32'h1234_5678);
		wr(EEPC_OFF_CMD, 32'(EEPC_CMD_PROG));
		wr(EEPC_OFF_CMD, 32'(EEPC_CMD_ERASE));
		rc(EEPC_OFF_STATUS, 32'h2a, "busy reject");
		wt_irq();
		rc(EEPC_OFF_STATUS, 32'h0, "clean finish");
		rc(EEPC_OFF_MIS, 32'h1, "masked set");
		wr(EEPC_OFF_CMD, 32'(EEPC_CMD_READ));
		rc(EEPC_OFF_RDATA, 32'h1234_5678, "readback");
	endtask : t_prog

	// Enable and clear act on bit 0 alone, flash mask on bit 2
	task automatic t_mask();
		wr(EEPC_OFF_IEN, 32'h0);
		rc(EEPC_OFF_RIS, 32'h1, "raw kept");
		rc(EEPC_OFF_MIS, 32'h0, "masked off");
		chk({31'h0, irq}, 32'h0, "irq disabled");
		wr(EEPC_OFF_IEN, 32'h1);
		wr(EEPC_OFF_FMASK, 32'h0);
		rc(EEPC_OFF_MIS, 32'h1, "masked on");
		chk({31'h0, irq}, 32'h0, "flash mask off");
		wr(EEPC_OFF_FMASK, 32'h4);
		rc(EEPC_OFF_ICLR, 32'h0, "clear reads zero");
		chk({31'h0, irq}, 32'h1, "flash mask on");
		wr(EEPC_OFF_ICLR, 32'hffff_fffe);
		rc(EEPC_OFF_RIS, 32'h1, "other bits no clear");
		wr(EEPC_OFF_ICLR, 32'h1);
		rc(EEPC_OFF_RIS, 32'h0, "cleared");
		chk({31'h0, irq}, 32'h0, "irq cleared");
	endtask : t_mask

	// Misaligned and out-of-range addresses are refused
	task automatic t_param();
		wr(EEPC_OFF_ADDR, 32'h6);
		wr(EEPC_OFF_CMD, 32'(EEPC_CMD_PROG));
		rc(EEPC_OFF_STATUS, 32'h1, "misaligned");
		wr(EEPC_OFF_ADDR, 32'h100);
		wr(EEPC_OFF_CMD, 32'(EEPC_CMD_READ));
		rc(EEPC_OFF_STATUS, 32'h1, "out of range");
		rc(EEPC_OFF_RIS, 32'h0, "no completion");
	endtask : t_param

	task automatic t_erase();
		wr(EEPC_OFF_CMD, 32'(EEPC_CMD_ERASE));
		rc(EEPC_OFF_STATUS, 32'h30, "erase working");
		for (int n = 0; n < 100 && protect_clear !== 1'b1; n++)
			@(posedge clock);
		chk({31'h0, protect_clear}, 32'h1, "protection dropped");
		wt_irq();
		rc(EEPC_OFF_STATUS, 32'h0, "erase ok");
		wr(EEPC_OFF_ADDR, 32'h8);
		wr(EEPC_OFF_CMD, 32'(EEPC_CMD_READ));
		rc(EEPC_OFF_RDATA, EEPC_ERASED, "erased word");
		wr(EEPC_OFF_ADDR, 32'hfc);
		wr(EEPC_OFF_CMD, 32'(EEPC_CMD_READ));
		rc(EEPC_OFF_RDATA, EEPC_ERASED, "last word");
	endtask : t_erase

	// Unmapped and read-only places
	task automatic t_unmapped();
		wr(8'h3c, 32'h5);
		chk({30'h0, rsp}, 32'h2, "unmapped write slverr");
		rc(8'h3c, 32'h0, "unmapped read");
		chk({30'h0, rsp}, 32'h0, "unmapped read okay");
		wr(EEPC_OFF_SIZE, 32'h0);
		rc(EEPC_OFF_SIZE, EEPC_SIZE_BYTES, "size read-only");
	endtask : t_unmapped

	task automatic conclude();
		$display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		ai = '0;
		rst = 1'b1;
		n_mismatch = 0;
		cmp_count = 0;
		repeat (6) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_prog();
		t_mask();
		t_param();
		t_erase();
		t_unmapped();
		conclude();
	end
endmodule : eeprom_program_status_irq_tb_top
